// *** hw/wtg_top.sv ***
// Write traffic generator and read-back checker toward a serial endpoint write slave port.
// Assumes an AXI4-Lite master for control and a slave port with waitrequest handshakes.
`timescale 1ns/1ps
`default_nettype none
`include "wtg_regs.svh"
module wtg_top
  import wtg_pkg::*;
#(
  parameter int DW = 64,
  parameter int AW = 5
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output wtg_cmd_t           ep_cmd,
  output logic [DW-1:0]      ep_wdata,
  input  wire logic          ep_waitrequest,
  input  wire logic [DW-1:0] ep_rdata,
  input  wire logic          ep_rdatavalid
);
  localparam int BB = DW / 8;

  // Beat count of a payload in bytes.
  function automatic logic [5:0] beats(input logic [8:0] bytes);
    beats = 6'(bytes / 9'(BB));
  endfunction

  // Data pattern from packet number and beat index.
  function automatic logic [DW-1:0] pat(input logic [31:0] pkt, input logic [5:0] bt);
    pat = {pkt, 26'h000_0000, bt} ^ {DW{1'b1}} >> 1;
  endfunction

  wtg_state_t  st_reg, st_next;
  logic        run_reg, run_next, dit_reg, dit_next;
  logic [8:0]  pload_reg, pload_next;
  logic [15:0] gap_reg, gap_next, gcnt_reg, gcnt_next;
  logic [3:0]  mode_reg, mode_next;
  logic [31:0] count_reg, count_next, tx_reg, tx_next, chk_reg, chk_next, err_reg, err_next;
  logic [7:0]  clk_reg, clk_next;
  logic [5:0]  beat_reg, beat_next;
  logic        bad_reg, bad_next;
  wtg_cmd_t    cmd_reg, cmd_next;
  logic [DW-1:0] wd_reg, wd_next;
  logic        aw_reg, aw_next, w_reg, w_next, bv_reg, bv_next, arr_reg, arr_next, rv_reg, rv_next;
  logic [7:0]  awa_reg, awa_next;
  logic [31:0] wdh_reg, wdh_next, rd_reg, rd_next;
  logic [1:0]  br_reg, br_next, rr_reg, rr_next;
  logic        mem_we;
  logic [DW-1:0] mem_rd;
  logic        wr_go, cmd_stop, cmd_start, cmd_dit;
  logic        awr_reg, awr_next, wrr_reg, wrr_next;

  wtg_mem #(.DW(DW), .AW(AW)) u_mem (
    .clk   (clk),
    .we    (mem_we),
    .waddr (beat_reg[AW-1:0]),
    .wdata (wd_reg), // The beat the slave takes now, not the one after it.
    .raddr (beat_next[AW-1:0]),
    .rdata (mem_rd)
  );

  assign wr_go     = aw_reg && w_reg && !bv_reg;
  assign cmd_stop  = wr_go && awa_reg == `WTG_OFF_CTRL && wdh_reg == `WTG_CMD_STOP;
  assign cmd_start = wr_go && awa_reg == `WTG_OFF_CTRL && wdh_reg == `WTG_CMD_START;
  assign cmd_dit   = wr_go && awa_reg == `WTG_OFF_CTRL && wdh_reg == `WTG_CMD_DIT;
  assign mem_we    = st_reg == WTG_WDATA && !ep_waitrequest;

  // Bus slave: address and data latched in either order, write performed once both held.
  always_comb begin
    aw_next = aw_reg; w_next = w_reg; awa_next = awa_reg; wdh_next = wdh_reg;
    bv_next = bv_reg; br_next = br_reg; arr_next = 1'b0; rv_next = rv_reg;
    rd_next = rd_reg; rr_next = rr_reg;
    pload_next = pload_reg; gap_next = gap_reg; mode_next = mode_reg;
    count_next = count_reg; clk_next = clk_reg;
    awr_next = s_axi_awvalid && !aw_reg && !awr_reg;
    wrr_next = s_axi_wvalid && !w_reg && !wrr_reg;
    if (s_axi_awvalid && awr_reg) begin
      aw_next = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wrr_reg) begin
      w_next = 1'b1;
      wdh_next = s_axi_wdata;
    end
    if (wr_go) begin
      bv_next = 1'b1;
      br_next = 2'b00;
      if (awa_reg == `WTG_OFF_PLOAD) begin
        if (wdh_reg[2:0] == 3'b000 && wdh_reg[31:0] >= 32'(`WTG_PLOAD_MIN)
            && wdh_reg[31:0] <= 32'(`WTG_PLOAD_MAX) && !run_reg) begin
          pload_next = wdh_reg[8:0];
        end else begin
          br_next = 2'b10;
        end
      end else if (awa_reg == `WTG_OFF_GAP) begin
        gap_next = wdh_reg[15:0];
      end else if (awa_reg == `WTG_OFF_MODE) begin
        if (wdh_reg == 32'(`WTG_MODE_ONE)) mode_next = wdh_reg[3:0];
        else br_next = 2'b10;
      end else if (awa_reg == `WTG_OFF_COUNT) begin
        count_next = wdh_reg;
      end else if (awa_reg == `WTG_OFF_CLKMHZ) begin
        clk_next = wdh_reg[7:0];
      end else if (awa_reg != `WTG_OFF_CTRL) begin
        br_next = 2'b10;
      end
    end
    if (bv_reg && s_axi_bready) begin
      bv_next = 1'b0; aw_next = 1'b0; w_next = 1'b0;
    end
    arr_next = s_axi_arvalid && !rv_reg && !arr_reg;
    if (s_axi_arvalid && arr_reg) begin
      rv_next = 1'b1;
      rr_next = 2'b00;
      if (s_axi_araddr == `WTG_OFF_PLOAD) rd_next = 32'(pload_reg);
      else if (s_axi_araddr == `WTG_OFF_GAP) rd_next = 32'(gap_reg);
      else if (s_axi_araddr == `WTG_OFF_MODE) rd_next = 32'(mode_reg);
      else if (s_axi_araddr == `WTG_OFF_COUNT) rd_next = count_reg;
      else if (s_axi_araddr == `WTG_OFF_STATUS) rd_next = {28'h000_0000, bad_reg, dit_reg,
                                                            run_reg, st_reg != WTG_IDLE};
      else if (s_axi_araddr == `WTG_OFF_TXCNT) rd_next = tx_reg;
      else if (s_axi_araddr == `WTG_OFF_CHKCNT) rd_next = chk_reg;
      else if (s_axi_araddr == `WTG_OFF_ERRCNT) rd_next = err_reg;
      else if (s_axi_araddr == `WTG_OFF_CLKMHZ) rd_next = 32'(clk_reg);
      else if (s_axi_araddr == `WTG_OFF_CTRL) rd_next = 32'h0000_0000;
      else begin
        rd_next = 32'h0000_0000;
        rr_next = 2'b10;
      end
    end
    if (rv_reg && s_axi_rready) rv_next = 1'b0;
  end

  // Generator and checker sequence.
  always_comb begin
    st_next = st_reg; run_next = run_reg; dit_next = dit_reg; gcnt_next = gcnt_reg;
    tx_next = tx_reg; chk_next = chk_reg; err_next = err_reg; beat_next = beat_reg;
    bad_next = bad_reg; cmd_next = cmd_reg; wd_next = wd_reg;
    if (cmd_stop) run_next = 1'b0;
    if ((cmd_start || cmd_dit) && st_reg == WTG_IDLE && !run_reg) begin
      run_next = 1'b1;
      dit_next = cmd_dit;
      tx_next = 32'h0000_0000;
      chk_next = 32'h0000_0000;
      err_next = 32'h0000_0000;
    end
    case (st_reg)
      WTG_IDLE: begin
        beat_next = 6'h00;
        if (run_reg && !(dit_reg && tx_reg == count_reg) && !cmd_stop) begin
          st_next = WTG_WDATA; // Write rises with the first data beat.
          cmd_next = '{write: 1'b1, read: 1'b0, ttype: `WTG_TT_NWRITE,
                       address: `WTG_BASE_ADDR, burstcount: beats(pload_reg)};
          wd_next = pat(tx_reg, 6'h00);
        end else if (run_reg && dit_reg) begin
          run_next = 1'b0;
        end
      end
      WTG_WDATA: begin
        if (!ep_waitrequest) begin
          beat_next = beat_reg + 6'h01;
          wd_next = pat(tx_reg, beat_reg + 6'h01);
          if (beat_reg == cmd_reg.burstcount - 6'h01) begin
            cmd_next.write = 1'b0;
            tx_next = tx_reg + 32'h0000_0001;
            beat_next = 6'h00;
            gcnt_next = gap_reg;
            if (dit_reg) begin
              st_next = WTG_RADDR;
              cmd_next.read = 1'b1;
              cmd_next.ttype = `WTG_TT_NREAD;
            end else begin
              st_next = WTG_GAP;
            end
          end
        end
      end
      WTG_RADDR: if (!ep_waitrequest) begin
        cmd_next.read = 1'b0;
        st_next = WTG_RDATA;
        bad_next = 1'b0;
      end
      WTG_RDATA: if (ep_rdatavalid) begin
        beat_next = beat_reg + 6'h01;
        if (ep_rdata != mem_rd) bad_next = 1'b1;
        if (beat_reg == cmd_reg.burstcount - 6'h01) begin
          chk_next = chk_reg + 32'h0000_0001;
          if (bad_reg || ep_rdata != mem_rd) err_next = err_reg + 32'h0000_0001;
          st_next = WTG_GAP;
          beat_next = 6'h00;
        end
      end
      WTG_GAP: begin
        if (gcnt_reg == 16'h0000) st_next = WTG_IDLE;
        else gcnt_next = gcnt_reg - 16'h0001;
      end
      default: st_next = WTG_IDLE;
    endcase
  end

  // Registers of both processes.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= WTG_IDLE; run_reg <= 1'b0; dit_reg <= 1'b0;
      pload_reg <= `WTG_PLOAD_RST; gap_reg <= `WTG_GAP_RST; mode_reg <= `WTG_MODE_ONE;
      count_reg <= 32'h0000_0000; clk_reg <= `WTG_CLK_RST; gcnt_reg <= 16'h0000;
      tx_reg <= 32'h0000_0000; chk_reg <= 32'h0000_0000; err_reg <= 32'h0000_0000;
      beat_reg <= 6'h00; bad_reg <= 1'b0; cmd_reg <= '0; wd_reg <= '0;
      aw_reg <= 1'b0; w_reg <= 1'b0; awa_reg <= 8'h00; wdh_reg <= 32'h0000_0000; awr_reg <= 1'b0;
      bv_reg <= 1'b0; br_reg <= 2'b00; arr_reg <= 1'b0; rv_reg <= 1'b0; wrr_reg <= 1'b0;
      rd_reg <= 32'h0000_0000; rr_reg <= 2'b00;
    end else begin
      st_reg <= st_next; run_reg <= run_next; dit_reg <= dit_next;
      pload_reg <= pload_next; gap_reg <= gap_next; mode_reg <= mode_next;
      count_reg <= count_next; clk_reg <= clk_next; gcnt_reg <= gcnt_next;
      tx_reg <= tx_next; chk_reg <= chk_next; err_reg <= err_next;
      beat_reg <= beat_next; bad_reg <= bad_next; cmd_reg <= cmd_next; wd_reg <= wd_next;
      aw_reg <= aw_next; w_reg <= w_next; awa_reg <= awa_next; wdh_reg <= wdh_next;
      bv_reg <= bv_next; br_reg <= br_next; arr_reg <= arr_next; rv_reg <= rv_next;
      rd_reg <= rd_next; rr_reg <= rr_next;
      awr_reg <= awr_next; wrr_reg <= wrr_next;
    end
  end

  // Readies are registered one-cycle pulses, so one request never yields two items.
  assign s_axi_awready = awr_reg;
  assign s_axi_wready  = wrr_reg;
  assign s_axi_bvalid  = bv_reg;
  assign s_axi_bresp   = br_reg;
  assign s_axi_arready = arr_reg;
  assign s_axi_rvalid  = rv_reg;
  assign s_axi_rdata   = rd_reg;
  assign s_axi_rresp   = rr_reg;
  assign ep_cmd        = cmd_reg;
  assign ep_wdata      = wd_reg;

  chk_stop_idle: assert property (@(posedge clk) disable iff (!nrst)
    cmd_stop && st_reg == WTG_IDLE |=> !ep_cmd.write) else $error("write after stop");
  chk_start_runs: assert property (@(posedge clk) disable iff (!nrst)
    cmd_start && st_reg == WTG_IDLE && !run_reg |=> ##1 ep_cmd.write) else $error("no burst");
  chk_gap_len: assert property (@(posedge clk) disable iff (!nrst)
    st_reg != WTG_GAP ##1 st_reg == WTG_GAP |-> gcnt_reg == gap_reg) else $error("gap load");
  chk_pload_range: assert property (@(posedge clk) disable iff (!nrst)
    pload_reg[2:0] == 3'b000 && pload_reg >= 9'h008 && pload_reg <= 9'h100) else $error("pload");
  chk_mode_one: assert property (@(posedge clk) disable iff (!nrst)
    mode_reg == 4'h1) else $error("mode not one");
  chk_nwrite_type: assert property (@(posedge clk) disable iff (!nrst)
    ep_cmd.write |-> ep_cmd.ttype == 2'h0) else $error("not nwrite");
  chk_dit_read: assert property (@(posedge clk) disable iff (!nrst)
    dit_reg && $fell(ep_cmd.write) |-> ep_cmd.read) else $error("no readback");
  chk_dit_count: assert property (@(posedge clk) disable iff (!nrst)
    dit_reg && run_reg |-> tx_reg <= count_reg) else $error("too many packets");
  chk_err_le_chk: assert property (@(posedge clk) disable iff (!nrst)
    err_reg <= chk_reg) else $error("errors exceed checks");
  cov_plain: cover property (@(posedge clk) disable iff (!nrst) !dit_reg && st_reg == WTG_GAP);
  cov_dit: cover property (@(posedge clk) disable iff (!nrst) st_reg == WTG_RDATA && ep_rdatavalid);
  cov_err: cover property (@(posedge clk) disable iff (!nrst) $rose(err_reg != 32'h0000_0000));
endmodule // wtg_top
`default_nettype wire

// *** hw/wtg_regs.svh ***
// Register offsets, command codes, payload limits, reset values and transaction types of the write traffic generator.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef WTG_REGS_SVH
`define WTG_REGS_SVH
`define WTG_OFF_CTRL     8'h00
`define WTG_OFF_PLOAD    8'h04
`define WTG_OFF_GAP      8'h08
`define WTG_OFF_MODE     8'h0C
`define WTG_OFF_COUNT    8'h10
`define WTG_OFF_STATUS   8'h14
`define WTG_OFF_TXCNT    8'h18
`define WTG_OFF_CHKCNT   8'h1C
`define WTG_OFF_ERRCNT   8'h20
`define WTG_OFF_CLKMHZ   8'h24
`define WTG_CMD_STOP     32'h0000_0001
`define WTG_CMD_START    32'h0000_0002
`define WTG_CMD_DIT      32'h0000_0003
`define WTG_PLOAD_MIN    9'h008
`define WTG_PLOAD_MAX    9'h100
`define WTG_PLOAD_RST    9'h100
`define WTG_GAP_RST      16'h0004
`define WTG_MODE_ONE     4'h1
`define WTG_CLK_RST      8'h4B
`define WTG_TT_NWRITE    2'h0
`define WTG_TT_NREAD     2'h1
`define WTG_BASE_ADDR    32'h0000_0000
`endif

// *** hw/wtg_pkg.sv ***
// Types shared by the write traffic generator and its payload store.
// Assumes the register header is on the include path.
`include "wtg_regs.svh"
package wtg_pkg;
  typedef enum logic [2:0] {
    WTG_IDLE  = 3'b000,
    WTG_WADDR = 3'b001,
    WTG_WDATA = 3'b010,
    WTG_GAP   = 3'b011,
    WTG_RADDR = 3'b100,
    WTG_RDATA = 3'b101
  } wtg_state_t;

  // One write-slave command toward the endpoint core.
  typedef struct packed {
    logic        write;
    logic        read;
    logic [1:0]  ttype;
    logic [31:0] address;
    logic [5:0]  burstcount;
  } wtg_cmd_t;
endpackage

// *** hw/wtg_mem.sv ***
// Small payload store that remembers the beats of the last written packet.
// Assumes one clock; read data comes out of a register one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
module wtg_mem
  import wtg_pkg::*;
#(
  parameter int DW = 64,
  parameter int AW = 5
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Write and registered read; no reset, so contents are only valid once written.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // wtg_mem
`default_nettype wire

// *** tb/wtg_ep_model.sv ***
// Behavioural model of the endpoint write slave port that the generator drives.
// Assumes the generator's clock and reset; it keeps the last burst and replays it on a read.
`timescale 1ns/1ps
`default_nettype none
`include "wtg_regs.svh"
module wtg_ep_model
  import wtg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire wtg_cmd_t    cmd,
  input  wire logic [63:0] wdata,
  input  wire logic        slow,
  input  wire logic        corrupt,
  output logic             waitreq,
  output logic [63:0]      rdata,
  output logic             rvalid,
  output int               wr_n,
  output int               rd_n,
  output int               type_err,
  output int               gap_min,
  output int               bc_last,
  output int               nb_last
);
  logic [63:0] mem [64];
  int          cnt;
  int          idx;
  int          left;
  int          low;
  int          nb;
  logic        wr_q;
  logic        rise;
  assign rise = cmd.write && !wr_q;
  // Stalls every other cycle when slow; idle read data is inverted so stale beats never match.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      waitreq <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      {wr_n, rd_n, type_err, cnt, idx, left, low, bc_last} <= '0;
      gap_min <= 999;
      wr_q <= 1'b0;
      nb <= 0;
      nb_last <= 0;
    end else begin
      waitreq <= slow ? !waitreq : 1'b0;
      wr_q <= cmd.write;
      low <= (cmd.write || cmd.read) ? 0 : low + 1;
      if (rise && wr_n > 0 && rd_n == 0 && low < gap_min)
        gap_min <= low;
      if (rise && cmd.ttype !== `WTG_TT_NWRITE)
        type_err <= type_err + 1;
      if (cmd.write && !waitreq) begin
        mem[6'((rise ? 0 : cnt))] <= wdata;
        cnt <= (rise ? 0 : cnt) + 1;
        bc_last <= int'(cmd.burstcount);
        nb <= nb + 1;
      end
      // Beats really taken per burst, so an extra write cycle shows up as a longer payload.
      if (!cmd.write && wr_q) begin
        wr_n <= wr_n + 1;
        nb_last <= nb;
        nb <= 0;
      end
      // A taken read replays the newest burstcount beats of the store.
      if (cmd.read && !waitreq && left == 0) begin
        left <= int'(cmd.burstcount);
        idx <= cnt - int'(cmd.burstcount);
        rd_n <= rd_n + 1;
        if (cmd.ttype !== `WTG_TT_NREAD)
          type_err <= type_err + 1;
      end
      rvalid <= left != 0;
      rdata <= (left != 0) ? (mem[6'(idx)] ^ {63'b0, corrupt}) : ~rdata;
      if (left != 0) begin
        left <= left - 1;
        idx <= idx + 1;
      end
    end
  end
endmodule // wtg_ep_model
`default_nettype wire

// *** tb/write_traffic_generator_checker_tb.sv ***
// Self-checking bench for the traffic generator: register access, free run and integrity runs.
// Assumes the endpoint model beside it and an AXI4-Lite master built from the tasks below.
`timescale 1ns/1ps
`default_nettype none
`include "wtg_regs.svh"
module write_traffic_generator_checker_tb
  import wtg_pkg::*;
;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rv;
  logic        clk = 0, nrst = 0, slow = 0, corrupt = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  wtg_cmd_t    ep_cmd;
  logic [63:0] ep_wdata, ep_rdata;
  logic        ep_waitrequest, ep_rdatavalid;
  int          wr_n, rd_n, type_err, gap_min, bc_last, nb_last, n0, r0;
  int          miscompares = 0, check_count = 0, cyc = 0;
  logic [31:0] bad [4] = '{32'h0000_0007, 32'h0000_0108, 32'h0000_000C, 32'h0000_0000};
  always #50 clk = ~clk;
  wtg_top i_dut (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ep_cmd, .ep_wdata, .ep_waitrequest, .ep_rdata, .ep_rdatavalid);
  wtg_ep_model i_ep (.clk, .nrst, .cmd(ep_cmd), .wdata(ep_wdata), .slow, .corrupt,
    .waitreq(ep_waitrequest), .rdata(ep_rdata), .rvalid(ep_rdatavalid), .wr_n, .rd_n,
    .type_err, .gap_min, .bc_last, .nb_last);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Sampling at the falling edge sees settled handshakes; release happens at the next rise.
  // Each call lets an edge pass first, so a strobe just released is never raised in one step.
  // Only the bench timeout ends a wait for an answer.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] r;
    b = 1'b0;
    r = 2'bxx;
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (!b) begin
      @(negedge clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    check({30'b0, r}, {30'b0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    logic ar, v;
    logic [1:0] r;
    v = 1'b0;
    r = 2'bxx;
    rv = 'x;
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    while (!v) begin
      @(negedge clk);
      ar = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      {r, rv} = {s_axi_rresp, s_axi_rdata};
      @(posedge clk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    check({30'b0, r}, {30'b0, er});
  endtask
  // Runs one integrity test of cnt packets and checks the counters it leaves behind.
  task automatic dit(input logic [31:0] cnt, input logic [31:0] errs);
    {n0, r0} = {wr_n, rd_n};
    wr(`WTG_OFF_CTRL, `WTG_CMD_STOP, 2'h0);
    wr(`WTG_OFF_COUNT, cnt, 2'h0);
    wr(`WTG_OFF_CTRL, `WTG_CMD_DIT, 2'h0);
    rd(`WTG_OFF_STATUS, 2'h0);
    check({30'b0, rv[2:1]}, 32'h0000_0003);
    for (int n = 0; n < 400 && rv[1]; n++)
      rd(`WTG_OFF_STATUS, 2'h0);
    rd(`WTG_OFF_TXCNT, 2'h0);
    check(rv, cnt);
    rd(`WTG_OFF_CHKCNT, 2'h0);
    check(rv, cnt);
    rd(`WTG_OFF_ERRCNT, 2'h0);
    check(rv, errs);
    check(32'(wr_n - n0), cnt);
    check(32'(rd_n - r0), cnt);
    $display("test integrity run of %0d packets done", cnt);
  endtask
  task automatic results();
    $display("checks %0d, miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // A hung handshake or run ends here instead of stalling the simulation.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(`WTG_OFF_PLOAD, 2'h0);
    check(rv, 32'h0000_0100);
    rd(`WTG_OFF_GAP, 2'h0);
    check(rv, 32'h0000_0004);
    rd(`WTG_OFF_MODE, 2'h0);
    check(rv, 32'h0000_0001);
    rd(`WTG_OFF_CLKMHZ, 2'h0);
    check(rv, 32'h0000_004B);
    rd(8'h30, 2'h2);
    check(rv, 32'h0000_0000);
    $display("test reset values done");
    foreach (bad[i]) wr(`WTG_OFF_PLOAD, bad[i], 2'h2);
    rd(`WTG_OFF_PLOAD, 2'h0);
    check(rv, 32'h0000_0100);
    wr(`WTG_OFF_MODE, 32'h0000_0002, 2'h2);
    wr(`WTG_OFF_MODE, 32'h0000_0001, 2'h0);
    wr(`WTG_OFF_CLKMHZ, 32'h0000_0054, 2'h0);
    rd(`WTG_OFF_CLKMHZ, 2'h0);
    check(rv, 32'h0000_0054);
    $display("test refusals done");
    wr(`WTG_OFF_PLOAD, 32'h0000_0010, 2'h0);
    wr(`WTG_OFF_CTRL, `WTG_CMD_START, 2'h0);
    repeat (200) @(posedge clk);
    wr(`WTG_OFF_PLOAD, 32'h0000_0008, 2'h2);
    wr(`WTG_OFF_CTRL, `WTG_CMD_STOP, 2'h0);
    repeat (60) @(posedge clk);
    n0 = wr_n;
    rd(`WTG_OFF_STATUS, 2'h0);
    check({31'b0, rv[1]}, 32'h0000_0000);
    repeat (100) @(posedge clk);
    check(32'(wr_n), 32'(n0));
    check({31'b0, wr_n > 10}, 32'h0000_0001);
    check(32'(bc_last), 32'h0000_0002);
    check(32'(nb_last), 32'h0000_0002);
    check(32'(type_err), 32'h0000_0000);
    check({31'b0, gap_min >= 4 && gap_min <= 7}, 32'h0000_0001);
    rd(`WTG_OFF_TXCNT, 2'h0);
    check(rv, 32'(wr_n));
    $display("test free run done");
    dit(32'h0000_0003, 32'h0000_0000);
    wr(`WTG_OFF_PLOAD, 32'h0000_0100, 2'h0);
    slow <= 1'b1;
    corrupt <= 1'b1;
    dit(32'h0000_0002, 32'h0000_0002);
    check(32'(bc_last), 32'h0000_0020);
    check(32'(nb_last), 32'h0000_0020);
    check(32'(type_err), 32'h0000_0000);
    results();
  end
endmodule // write_traffic_generator_checker_tb
`default_nettype wire
